// ### arc_pkg.sv
package arc_pkg;

	// Register window offsets (byte addresses in the memory window)
	localparam logic [11:0] ARC_SELFTEST_RESET_CONTROL_OFS = 12'h10c;
	localparam logic [11:0] ARC_CONFIG_STATUS_OFS          = 12'h110;
	localparam int          ARC_ADDR_W                     = 12;
	localparam int          ARC_DATA_W                     = 32;

	// Self-test and reset control field positions
	localparam int ARC_LAST_CAUSE_MSB  = 31;
	localparam int ARC_LAST_CAUSE_LSB  = 28;
	localparam int ARC_DONE_BIT        = 26;
	localparam int ARC_RSVD_HI_MSB     = 25;
	localparam int ARC_RSVD_HI_LSB     = 24;
	localparam int ARC_HOLD_BIT        = 23;
	localparam int ARC_CLR_MASK_BIT    = 22;
	localparam int ARC_FLASH_MASK_BIT  = 9;
	localparam int ARC_SET_MASK_BIT    = 6;
	localparam int ARC_PULSE_BIT       = 5;
	localparam int ARC_ASSERT_BIT      = 4;
	localparam int ARC_SOFT_RESET_BIT  = 1;
	localparam int ARC_START_TEST_BIT  = 0;

	// Configuration/status field position
	localparam int ARC_PORT_ENABLE_BIT = 21;

	// Last reset cause encodings
	localparam logic [3:0] ARC_CAUSE_SOFT  = 4'h9;
	localparam logic [3:0] ARC_CAUSE_TEST  = 4'hc;
	localparam logic [3:0] ARC_CAUSE_PCI   = 4'hf;

	// Reset values of the stored control bits
	localparam logic       ARC_DONE_RST    = 1'b1;
	localparam logic [1:0] ARC_RSVD_HI_RST = 2'b11;
	localparam logic       ARC_HOLD_RST    = 1'b0; // Processor runs so firmware can open the port
	localparam logic       ARC_MASK_RST    = 1'b0;
	localparam logic       ARC_ENABLE_RST  = 1'b0;

	// Timing
	localparam int ARC_CLK_PERIOD_PS  = 8000;
	localparam int ARC_PULSE_TIME_US  = 3;
	localparam int ARC_PULSE_CYCLES   =
		(ARC_PULSE_TIME_US * 1000000 + ARC_CLK_PERIOD_PS - 1) / ARC_CLK_PERIOD_PS;
	localparam int ARC_SOFT_RST_CYCLES = 16;

	// Sequencer states
	typedef enum logic [1:0] {
		ARC_IDLE      = 2'b00,
		ARC_SOFT_RST  = 2'b01,
		ARC_SELF_TEST = 2'b10
	} arc_seq_t;

endpackage

// ### arc_cycle_timer.sv
`timescale 1ns/10ps

// One-shot cycle timer: busy for CYCLES edges after start, done pulses at the end
module arc_cycle_timer
	import arc_pkg::*;
#(
	parameter int CYCLES = ARC_PULSE_CYCLES,
	parameter int CNT_W  = $clog2(CYCLES + 1)
)
(
	input  wire logic clk,     // System clock
	input  wire logic reset_n, // Asynchronous reset, active low
	input  wire logic start,   // Start or restart the interval
	output logic      busy,    // High while the interval runs
	output logic      done     // One-cycle pulse at the end
);

	localparam logic [CNT_W-1:0] LOAD_VAL = CNT_W'(CYCLES);
	localparam logic [CNT_W-1:0] ONE      = CNT_W'(1);

	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;
	logic             done_r;
	logic             done_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Next count; a restart while busy stretches the interval
	always_comb
	begin
		count_nxt = count_r;
		done_nxt  = 1'b0;
		if (start)
			count_nxt = LOAD_VAL;
		else if (count_r != '0)
		begin
			count_nxt = count_r - ONE;
			done_nxt  = (count_r == ONE);
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count_r <= '0;
			done_r  <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			done_r  <= done_nxt;
		end
	end

	assign busy = (count_r != '0);
	assign done = done_r;

endmodule // arc_cycle_timer

// ### adapter_reset_control.sv
// Overview of operation
// - Mask clear: flash reset follows processor reset
// - Mask set: flash reset held inactive
// - Set-mask command sets mask, reads zero
// - Pulse command resets processor three microseconds
// - Assert command sets hold, reads zero
// - Soft reset resets adapter, keeps configuration
// - Start bit runs self-test, sets done
// - Port enable cleared by resets, test start
// - Firmware sets port enable after reset
// - Configuration/status is read only
// - Done flag cleared by writing one
// - Hold bit shows reset; write one releases
// - Clear-mask command clears mask, reads zero
// - Cause field records most recent reset

`timescale 1ns/10ps

module adapter_reset_control
	import arc_pkg::*;
#(
	parameter int PULSE_CYCLES    = ARC_PULSE_CYCLES,
	parameter int SOFT_RST_CYCLES = ARC_SOFT_RST_CYCLES
)
(
	input  wire logic                  clk,                  // 125 MHz clock
	input  wire logic                  reset_n,              // PCI bus reset, active low
	input  wire logic                  reg_wr,               // Register write strobe
	input  wire logic                  reg_rd,               // Register read strobe
	input  wire logic [ARC_ADDR_W-1:0] reg_addr,             // Byte address in window
	input  wire logic [ARC_DATA_W-1:0] reg_wdata,            // Write data
	output logic      [ARC_DATA_W-1:0] reg_rdata,            // Read data, registered
	output logic                       reg_rvalid,           // Read data valid pulse
	input  wire logic                  fw_port_enable_set,   // Firmware sets port enable
	input  wire logic                  self_test_complete,   // Self-test engine finished
	output logic                       cpu_reset_n,          // Local processor reset
	output logic                       flash_reset_n,        // Flash memory reset
	output logic                       adapter_soft_reset,   // Adapter-wide reset
	output logic                       self_test_run,        // Self-test engine enable
	output logic                       request_port_enable   // Request/reply port open
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic           wr_ctrl;
	logic           rd_hit_ctrl;
	logic           rd_hit_stat;
	logic           set_mask_cmd;
	logic           clr_mask_cmd;
	logic           pulse_cmd;
	logic           assert_cmd;
	logic           release_cmd;
	logic           soft_cmd;
	logic           test_cmd;
	logic           done_clr_cmd;
	logic [1:0]     rsvd_clr_cmd;

	logic           pulse_busy;
	logic           soft_busy;
	logic           soft_done;
	logic           soft_start;
	logic           test_start;

	arc_seq_t       seq_r;
	arc_seq_t       seq_nxt;
	logic [3:0]     cause_r;
	logic [3:0]     cause_nxt;
	logic           done_r;
	logic           done_nxt;
	logic [1:0]     rsvd_hi_r;
	logic [1:0]     rsvd_hi_nxt;
	logic           hold_r;
	logic           hold_nxt;
	logic           mask_r;
	logic           mask_nxt;
	logic           enable_r;
	logic           enable_nxt;

	logic           cpu_rst_active;
	logic           cpu_reset_n_r;
	logic           cpu_reset_n_nxt;
	logic           flash_reset_n_r;
	logic           flash_reset_n_nxt;

	logic [ARC_DATA_W-1:0] rdata_r;
	logic [ARC_DATA_W-1:0] rdata_nxt;
	logic                  rvalid_r;
	logic                  rvalid_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Address decode and command strobes

	// Writes to the status word decode to nothing, so it cannot be altered
	assign wr_ctrl      = reg_wr && (reg_addr == ARC_SELFTEST_RESET_CONTROL_OFS);
	assign rd_hit_ctrl  = (reg_addr == ARC_SELFTEST_RESET_CONTROL_OFS);
	assign rd_hit_stat  = (reg_addr == ARC_CONFIG_STATUS_OFS);

	// Command bits are strobes only; nothing stores them
	assign set_mask_cmd = wr_ctrl && reg_wdata[ARC_SET_MASK_BIT];
	assign clr_mask_cmd = wr_ctrl && reg_wdata[ARC_CLR_MASK_BIT];
	assign pulse_cmd    = wr_ctrl && reg_wdata[ARC_PULSE_BIT];
	assign assert_cmd   = wr_ctrl && reg_wdata[ARC_ASSERT_BIT];
	assign release_cmd  = wr_ctrl && reg_wdata[ARC_HOLD_BIT];
	assign soft_cmd     = wr_ctrl && reg_wdata[ARC_SOFT_RESET_BIT];
	assign test_cmd     = wr_ctrl && reg_wdata[ARC_START_TEST_BIT];
	assign done_clr_cmd = wr_ctrl && reg_wdata[ARC_DONE_BIT];
	assign rsvd_clr_cmd = wr_ctrl ? reg_wdata[ARC_RSVD_HI_MSB:ARC_RSVD_HI_LSB] : 2'h0;

	// Bits three and two are ignored on write; software must keep them zero

	// A soft reset takes priority over a self-test requested in the same write
	assign soft_start   = soft_cmd;
	assign test_start   = test_cmd && !soft_cmd && (seq_r == ARC_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// Timers: processor reset pulse and soft reset interval

	// Pulse length rounds up so the reset lasts at least the full time
	arc_cycle_timer #(
		.CYCLES (PULSE_CYCLES)
	) u_pulse_timer (
		.clk     (clk),
		.reset_n (reset_n),
		.start   (pulse_cmd),
		.busy    (pulse_busy),
		.done    ()
	);

	arc_cycle_timer #(
		.CYCLES (SOFT_RST_CYCLES)
	) u_soft_timer (
		.clk     (clk),
		.reset_n (reset_n),
		.start   (soft_start),
		.busy    (soft_busy),
		.done    (soft_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// Reset sequencer and control bits

	// Hardware sets win over host clears arriving in the same cycle
	always_comb
	begin
		seq_nxt     = seq_r;
		cause_nxt   = cause_r;
		done_nxt    = done_r;
		rsvd_hi_nxt = rsvd_hi_r & ~rsvd_clr_cmd;
		hold_nxt    = hold_r;
		mask_nxt    = mask_r;
		enable_nxt  = enable_r;

		// Host clears the done flag by writing one
		if (done_clr_cmd)
			done_nxt = 1'b0;

		// Mask commands; set wins if both arrive together
		if (clr_mask_cmd)
			mask_nxt = 1'b0;
		if (set_mask_cmd)
			mask_nxt = 1'b1;

		// Hold bit: write one releases, assert command sets
		if (release_cmd)
			hold_nxt = 1'b0;
		if (assert_cmd)
			hold_nxt = 1'b1;

		unique case (seq_r)
			ARC_IDLE:
			begin
				if (test_start)
				begin
					seq_nxt   = ARC_SELF_TEST;
					cause_nxt = ARC_CAUSE_TEST;
				end
			end
			ARC_SOFT_RST:
			begin
				// Self-test is not run; only the done flag is raised at the end
				if (soft_done)
				begin
					seq_nxt  = ARC_IDLE;
					done_nxt = 1'b1;
				end
			end
			ARC_SELF_TEST:
			begin
				if (self_test_complete)
				begin
					seq_nxt  = ARC_IDLE;
					done_nxt = 1'b1;
				end
			end
			default:
			begin
				seq_nxt = ARC_IDLE;
			end
		endcase

		// Soft reset restarts the adapter side from any state
		if (soft_start)
		begin
			seq_nxt     = ARC_SOFT_RST;
			cause_nxt   = ARC_CAUSE_SOFT;
			hold_nxt    = ARC_HOLD_RST;
			mask_nxt    = ARC_MASK_RST;
			rsvd_hi_nxt = ARC_RSVD_HI_RST;
		end

		// Port closes on soft reset or test start; firmware reopens it
		if (soft_start || test_start)
			enable_nxt = 1'b0;
		if (fw_port_enable_set)
			enable_nxt = 1'b1;
	end

	// Bus reset values; the cause field reads as the bus reset code
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			seq_r     <= ARC_IDLE;
			cause_r   <= ARC_CAUSE_PCI;
			done_r    <= ARC_DONE_RST;
			rsvd_hi_r <= ARC_RSVD_HI_RST;
			hold_r    <= ARC_HOLD_RST;
			mask_r    <= ARC_MASK_RST;
			enable_r  <= ARC_ENABLE_RST;
		end
		else
		begin
			seq_r     <= seq_nxt;
			cause_r   <= cause_nxt;
			done_r    <= done_nxt;
			rsvd_hi_r <= rsvd_hi_nxt;
			hold_r    <= hold_nxt;
			mask_r    <= mask_nxt;
			enable_r  <= enable_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset outputs

	// Processor reset: held, pulsed, or inside a soft reset
	assign cpu_rst_active = hold_r || pulse_busy || soft_busy;

	always_comb
	begin
		cpu_reset_n_nxt = !cpu_rst_active;
		// With the mask set the flash stays out of reset during updates
		if (mask_r)
			flash_reset_n_nxt = 1'b1;
		else
			flash_reset_n_nxt = !cpu_rst_active;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cpu_reset_n_r   <= 1'b0;
			flash_reset_n_r <= 1'b0;
		end
		else
		begin
			cpu_reset_n_r   <= cpu_reset_n_nxt;
			flash_reset_n_r <= flash_reset_n_nxt;
		end
	end

	assign cpu_reset_n         = cpu_reset_n_r;
	assign flash_reset_n       = flash_reset_n_r;
	assign adapter_soft_reset  = soft_busy;
	assign self_test_run       = (seq_r == ARC_SELF_TEST);
	assign request_port_enable = enable_r;

	////////////////////////////////////////////////////////////////////////////
	// Read path

	// Command bits and reserved bits other than 25-24 read zero; unmapped addresses read zero
	always_comb
	begin
		rdata_nxt  = '0;
		rvalid_nxt = reg_rd;
		if (reg_rd && rd_hit_ctrl)
		begin
			rdata_nxt[ARC_LAST_CAUSE_MSB:ARC_LAST_CAUSE_LSB] = cause_r;
			rdata_nxt[ARC_DONE_BIT]                          = done_r;
			rdata_nxt[ARC_RSVD_HI_MSB:ARC_RSVD_HI_LSB]       = rsvd_hi_r;
			rdata_nxt[ARC_HOLD_BIT]                          = cpu_rst_active;
			rdata_nxt[ARC_FLASH_MASK_BIT]                    = mask_r;
		end
		else if (reg_rd && rd_hit_stat)
		begin
			// Status word shows only the port enable
			rdata_nxt[ARC_PORT_ENABLE_BIT] = enable_r;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdata_r  <= '0;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign reg_rdata  = rdata_r;
	assign reg_rvalid = rvalid_r;

	// Software polls the status word; the port-enable rise means ready
	// Flash update order is software's duty; hardware keeps mask and hold apart

endmodule // adapter_reset_control

// ### arc_reset_asserts.sv
`timescale 1ns/10ps

module arc_reset_asserts
	import arc_pkg::*;
#(
	parameter int PULSE_CYCLES    = ARC_PULSE_CYCLES,
	parameter int SOFT_RST_CYCLES = ARC_SOFT_RST_CYCLES
)
(
	input wire logic                  clk,                 // Clock
	input wire logic                  reset_n,             // Reset, active low
	input wire logic                  reg_wr,              // Write strobe
	input wire logic                  reg_rd,              // Read strobe
	input wire logic [ARC_ADDR_W-1:0] reg_addr,            // Address
	input wire logic [ARC_DATA_W-1:0] reg_wdata,           // Write data
	input wire logic [ARC_DATA_W-1:0] reg_rdata,           // Read data
	input wire logic                  reg_rvalid,          // Read valid
	input wire logic                  fw_port_enable_set,  // Firmware set
	input wire logic                  self_test_complete,  // Test finished
	input wire logic                  cpu_reset_n,         // Processor reset
	input wire logic                  flash_reset_n,       // Flash reset
	input wire logic                  adapter_soft_reset,  // Adapter reset
	input wire logic                  self_test_run,       // Test running
	input wire logic                  request_port_enable  // Port enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////////////
	logic        pulse_wr;
	logic [15:0] since_r, since_nxt, soft_cnt_r, soft_cnt_nxt;

	// Saturating age of the last pulse write; saturated after reset so no false rise
	assign pulse_wr = reg_wr && reg_addr == ARC_SELFTEST_RESET_CONTROL_OFS && reg_wdata[ARC_PULSE_BIT];
	always_comb
	begin
		since_nxt = (since_r == 16'hffff) ? since_r : since_r + 16'h1;
		if (pulse_wr)
			since_nxt = 16'h0;
		soft_cnt_nxt = adapter_soft_reset ? soft_cnt_r + 16'h1 : 16'h0;
	end

	// Helper registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			since_r    <= 16'hffff;
			soft_cnt_r <= 16'h0;
		end
		else
		begin
			since_r    <= since_nxt;
			soft_cnt_r <= soft_cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	flash_mask_a: assert property (!flash_reset_n |-> !cpu_reset_n)
		else $error("flash reset active without processor reset");
	read_answer_a: assert property (reg_rvalid == $past(reg_rd))
		else $error("read valid does not follow the read strobe");
	status_ro_a: assert property (reg_rd && reg_addr == ARC_CONFIG_STATUS_OFS
		|=> (reg_rdata & ~(32'h1 << ARC_PORT_ENABLE_BIT)) == 32'h0)
		else $error("status reserved bits not zero");
	cmd_zero_a: assert property (reg_rd && reg_addr == ARC_SELFTEST_RESET_CONTROL_OFS
		|=> reg_rdata[22] == 1'b0 && reg_rdata[8:0] == 9'h0 && reg_rdata[27] == 1'b0)
		else $error("command or reserved bit read nonzero");
	pulse_start_a: assert property (pulse_wr |-> ##2 !cpu_reset_n)
		else $error("pulse did not assert processor reset");
	pulse_len_a: assert property ($rose(cpu_reset_n) |-> since_r >= PULSE_CYCLES)
		else $error("processor reset pulse too short");
	soft_len_a: assert property ($fell(adapter_soft_reset) |-> soft_cnt_r == SOFT_RST_CYCLES)
		else $error("soft reset length wrong");
	port_clear_a: assert property ($rose(adapter_soft_reset) || $rose(self_test_run)
		|-> ##[0:1] !request_port_enable)
		else $error("port enable not cleared");
	port_set_a: assert property (fw_port_enable_set |=> request_port_enable)
		else $error("port enable not set by firmware");
	test_end_a: assert property (self_test_run && self_test_complete |=> !self_test_run)
		else $error("self-test did not stop on completion");
endmodule // arc_reset_asserts

bind adapter_reset_control arc_reset_asserts #(
	.PULSE_CYCLES(PULSE_CYCLES), .SOFT_RST_CYCLES(SOFT_RST_CYCLES)
) chk_u (.*);

// ### arc_host_model.sv
`timescale 1ns/10ps

module arc_host_model
	import arc_pkg::*;
(
	input  wire logic                  clk,        // Clock
	output logic                       reg_wr,     // Write strobe
	output logic                       reg_rd,     // Read strobe
	output logic      [ARC_ADDR_W-1:0] reg_addr,   // Address
	output logic      [ARC_DATA_W-1:0] reg_wdata,  // Write data
	input  wire logic [ARC_DATA_W-1:0] reg_rdata,  // Read data
	input  wire logic                  reg_rvalid  // Read valid
);
	// Idle bus; data shows a changing pattern once released
	initial
	begin
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 12'h0;
		reg_wdata = 32'h0;
	end

	// One write cycle; reserved bits 3-2 are never set by software
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d & ~32'hc;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// One read cycle, bounded wait for the valid pulse
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		d = 32'hdead_beef;
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			if (reg_rvalid === 1'b1)
			begin
				d = reg_rdata;
				break;
			end
		end
	endtask

	// Readiness is the port enable bit turning to one
	task automatic poll_ready(output logic ok);
		logic [31:0] d;
		ok = 1'b0;
		for (int i = 0; i < 8 && !ok; i++)
		begin
			rd(ARC_CONFIG_STATUS_OFS, d);
			ok = (d[ARC_PORT_ENABLE_BIT] === 1'b1);
		end
	endtask
endmodule // arc_host_model

// ### tb_top.sv
`timescale 1ns/10ps

module tb_top
	import arc_pkg::*;
;
	localparam int P = 20;
	localparam int S = 4;
	localparam logic [11:0] CA = ARC_SELFTEST_RESET_CONTROL_OFS;
	localparam logic [11:0] SA = ARC_CONFIG_STATUS_OFS;

	logic clk, reset_n, reg_wr, reg_rd, reg_rvalid, fw_set, st_done, ok;
	logic cpu_reset_n, flash_reset_n, soft_rst, st_run, port_en;
	logic [11:0] reg_addr, a;
	logic [31:0] reg_wdata, reg_rdata, d;
	int err_count, n_tests, cnt;

	adapter_reset_control #(.PULSE_CYCLES(P), .SOFT_RST_CYCLES(S)) dut_u (
		.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.fw_port_enable_set(fw_set), .self_test_complete(st_done), .cpu_reset_n(cpu_reset_n),
		.flash_reset_n(flash_reset_n), .adapter_soft_reset(soft_rst), .self_test_run(st_run),
		.request_port_enable(port_en));
	arc_host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	////////////////////////////////////////////////////////////////////////////////
	// Expected control word from cause, done, hold and mask
	function automatic logic [31:0] ctl(logic [3:0] c, logic dn, logic h, logic m);
		return {c, 1'b0, dn, 2'b11, h, 13'h0, m, 9'h0};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic pins(input logic c, input logic f);
		repeat (3) @(posedge clk);
		chk({31'h0, cpu_reset_n}, {31'h0, c});
		chk({31'h0, flash_reset_n}, {31'h0, f});
	endtask

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Free-running clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Watchdog against a hung handshake
	initial
	begin
		repeat (6000) @(posedge clk);
		err_count++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		err_count = 0;
		n_tests = 0;
		reset_n = 1'b0;
		fw_set = 1'b0;
		st_done = 1'b0;
		void'($urandom(32'h40616500));
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		pins(1'b1, 1'b1);
		host_u.rd(CA, d);
		chk(d, ctl(ARC_CAUSE_PCI, 1'b1, 1'b0, 1'b0));
		host_u.rd(SA, d);
		chk(d, 32'h0);
		host_u.wr(CA, 32'h0080_0000);
		pins(1'b1, 1'b1);
		// Flash update order, host side
		host_u.wr(CA, 32'h10);
		pins(1'b0, 1'b0);
		host_u.wr(CA, 32'h40);
		pins(1'b0, 1'b1);
		host_u.rd(CA, d);
		chk(d, ctl(ARC_CAUSE_PCI, 1'b1, 1'b1, 1'b1));
		host_u.wr(CA, 32'h0040_0000);
		pins(1'b0, 1'b0);
		host_u.wr(CA, 32'h0080_0000);
		pins(1'b1, 1'b1);
		// Pulse length in cycles
		host_u.wr(CA, 32'h20);
		cnt = 0;
		// Pins are looked at on the falling edge, where they have settled
		for (int i = 0; i < 8 && cpu_reset_n !== 1'b0; i++)
			@(negedge clk);
		while (cpu_reset_n === 1'b0 && cnt < 4 * P)
		begin
			@(negedge clk);
			cnt++;
		end
		chk({31'h0, cnt >= P && cnt <= P + 2}, 32'h1);
		host_u.wr(CA, 32'h0400_0000);
		host_u.rd(CA, d);
		chk(d, ctl(ARC_CAUSE_PCI, 1'b0, 1'b0, 1'b0));
		// Soft reset with done cleared beforehand
		host_u.wr(CA, 32'h2);
		repeat (2) @(negedge clk);
		chk({30'h0, soft_rst, cpu_reset_n}, 32'h2);
		repeat (S + 6) @(posedge clk);
		host_u.rd(CA, d);
		chk(d, ctl(ARC_CAUSE_SOFT, 1'b1, 1'b0, 1'b0));
		chk({30'h0, soft_rst, cpu_reset_n}, 32'h1);
		chk({31'h0, port_en}, 32'h0);
		@(posedge clk) fw_set <= 1'b1;
		@(posedge clk) fw_set <= 1'b0;
		host_u.poll_ready(ok);
		chk({31'h0, ok}, 32'h1);
		// Random writes into the status word leave it alone
		for (int i = 0; i < 8; i++)
		begin
			host_u.wr(SA, $urandom);
			host_u.rd(SA, d);
			chk(d, 32'h0020_0000);
			a = 12'($urandom) & 12'hffc;
			host_u.rd(a, d);
			if (a != CA && a != SA)
				chk(d, 32'h0);
		end
		// Bus reset in mid-run closes the port and records its cause
		@(posedge clk) reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		host_u.rd(SA, d);
		chk(d, 32'h0);
		host_u.rd(CA, d);
		chk(d, ctl(ARC_CAUSE_PCI, 1'b1, 1'b0, 1'b0));
		// Self-test start and completion
		host_u.wr(CA, 32'h0400_0000);
		host_u.wr(CA, 32'h1);
		repeat (3) @(posedge clk);
		chk({30'h0, st_run, port_en}, 32'h2);
		host_u.rd(CA, d);
		chk(d, ctl(ARC_CAUSE_TEST, 1'b0, 1'b0, 1'b0));
		@(posedge clk) st_done <= 1'b1;
		@(posedge clk) st_done <= 1'b0;
		repeat (3) @(posedge clk);
		host_u.rd(CA, d);
		chk({d[31:1], st_run}, {ctl(ARC_CAUSE_TEST, 1'b1, 1'b0, 1'b0)});
		end_of_test();
	end
endmodule // tb_top
